// ---- design/lrm_regs.vh ----
/*
  Shared constants of the large dual-port RAM with byte-lane write masks:
  width codes, clocking-mode codes, geometry and reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef LRM_REGS_VH
`define LRM_REGS_VH

// Port width codes (9-bit lanes; with lane8 set the 8-bit variant)
`define LRM_W18 2'd0
`define LRM_W36 2'd1
`define LRM_W72 2'd2
`define LRM_W144 2'd3

// Clocking-mode codes
`define LRM_CK_INDEP 2'd0
`define LRM_CK_INOUT 2'd1
`define LRM_CK_RDWR 2'd2

// Geometry
`define LRM_DATA_W 72
`define LRM_ROW_W 144
`define LRM_ROW_AW 12
`define LRM_ADDR_W 16
`define LRM_LANES 8
`define LRM_LANE_W 9
`define LRM_BYTE_W 8

// Lane masks enabled by each width
`define LRM_MASK_W18 8'h03
`define LRM_MASK_W36 8'h0f
`define LRM_MASK_ALL 8'hff

// Reset and clear values
`define LRM_RST_ADDR 16'h0000
`define LRM_RST_DATA 72'h000000000000000000
`define LRM_RST_ROW 144'h0
`define LRM_RST_LANE 8'hff
`define LRM_RST_SH 8'h00

`endif

// ---- design/lrm_mem.v ----
/*
  Storage array of the dual-port RAM: two ports, each with a bit-masked
  write and an enabled read whose data come out of a register.
  Assumes one clock and a synchronous active-high reset for the read
  registers only; array contents are never reset or preloaded.
*/
`timescale 1ns/10ps
`include "lrm_regs.vh"

module lrm_mem #(
  parameter ROW_W = `LRM_ROW_W,
  parameter ROW_AW = `LRM_ROW_AW
) (
  input wire core_clk,
  input wire srst,
  input wire a_wr,
  input wire a_rd,
  input wire [ROW_AW-1:0] a_addr,
  input wire [ROW_W-1:0] a_wdata,
  input wire [ROW_W-1:0] a_wmask,
  output reg [ROW_W-1:0] a_rdata_q,
  input wire b_wr,
  input wire b_rd,
  input wire [ROW_AW-1:0] b_addr,
  input wire [ROW_W-1:0] b_wdata,
  input wire [ROW_W-1:0] b_wmask,
  output reg [ROW_W-1:0] b_rdata_q
);

  // Contents stay undefined until written
  reg [ROW_W-1:0] mem_q [0:(1<<ROW_AW)-1];
  integer i;

  // Masked writes; port B lands last on a shared row
  always @(posedge core_clk)
  begin
    for (i = 0; i < ROW_W; i = i + 1)
    begin
      if (a_wr && a_wmask[i])
        mem_q[a_addr][i] <= a_wdata[i];
      if (b_wr && b_wmask[i])
        mem_q[b_addr][i] <= b_wdata[i];
    end
  end

  // Registered reads, old data on a same-cycle write
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      a_rdata_q <= {ROW_W{1'b0}};
      b_rdata_q <= {ROW_W{1'b0}};
    end
    else
    begin
      if (a_rd)
        a_rdata_q <= mem_q[a_addr];
      if (b_rd)
        b_rdata_q <= mem_q[b_addr];
    end
  end

endmodule

// ---- design/lrm_ram.v ----
/*
  Large dual-port RAM with per-lane write masking, true or simple
  dual-port operation, three clocking modes mapped onto enables and
  clears of one clock, and an optional output register per port.
  Assumes all inputs come from fabric logic on core_clk and that the
  configuration inputs change only while the block is idle.
*/
`timescale 1ns/10ps
`include "lrm_regs.vh"

//Contract
// - The write strobe alone picks read or write; no read strobe on true ports.
// - A lane writes only with strobe and its mask bit; masks default high.
// - Lane masking works in the 18, 36 and 72 bit widths.
// - In 144-bit simple mode both ports' masks merge into sixteen lanes.
// - Mask bit k gates data bits 9k to 9k+8 for 18/36/72 widths.
// - In 144-bit width merged mask bit k gates bits 9k to 9k+8.
// - Any combination of mask bits may be set; lanes act independently.
// - In 16/32/64/128 widths the same masks gate 8-bit lanes.
// - Strobe, data, address and mask registers of a port share one clock.
// - The output register is optional; bypass drops that stage.
// - Each port has 72 data inputs and 72 data outputs.
// - Independent mode: port A registers follow A, port B registers follow B; in simple operation B's data and mask registers follow A.
// - Independent mode: each port has its own enable and clear.
// - Input/output mode: input registers and output registers share core_clk but have separate enables.
// - Input/output mode: separate enables and clears for input and output sides.
// - Read/write mode: write side holds data, masks, write address, strobe; read side the rest.
// - Read/write mode: each side has its own enable and its own clear.
// - In simple modes the read strobe register has no clear.
// - Only synchronous operation; every input is registered before use.
// - Contents are undefined at power-up and cannot be preloaded.
// - The 144-bit width is refused in true dual-port operation.
module lrm_ram #(
  parameter ROW_AW = `LRM_ROW_AW
) (
  input wire core_clk,
  input wire srst,
  input wire cfg_simple,
  input wire [1:0] cfg_width,
  input wire cfg_lane8,
  input wire [1:0] cfg_clk_mode,
  input wire cfg_out_reg_a,
  input wire cfg_out_reg_b,
  input wire a_in_clken,
  input wire a_out_clken,
  input wire a_in_clr,
  input wire a_out_clr,
  input wire a_we,
  input wire [`LRM_ADDR_W-1:0] a_addr,
  input wire [`LRM_DATA_W-1:0] a_din,
  input wire [`LRM_LANES-1:0] a_lane_en,
  output reg [`LRM_DATA_W-1:0] a_dout_q,
  input wire b_in_clken,
  input wire b_out_clken,
  input wire b_in_clr,
  input wire b_out_clr,
  input wire b_we,
  input wire b_rd_en,
  input wire [`LRM_ADDR_W-1:0] b_addr,
  input wire [`LRM_DATA_W-1:0] b_din,
  input wire [`LRM_LANES-1:0] b_lane_en,
  output reg [`LRM_DATA_W-1:0] b_dout_q,
  output reg cfg_fault_q
);

  // Lane mask of the lanes that exist in a width
  function [`LRM_LANES-1:0] lrm_wmask;
    input [1:0] w;
    begin
      case (w)
        `LRM_W18: lrm_wmask = `LRM_MASK_W18;
        `LRM_W36: lrm_wmask = `LRM_MASK_W36;
        default: lrm_wmask = `LRM_MASK_ALL;
      endcase
    end
  endfunction

  // One mask bit widened over its 9-bit lane
  function [`LRM_DATA_W-1:0] lrm_lanes;
    input [`LRM_LANES-1:0] en;
    integer k;
    begin
      lrm_lanes = `LRM_RST_DATA;
      for (k = 0; k < `LRM_LANES; k = k + 1)
        lrm_lanes[k*`LRM_LANE_W +: `LRM_LANE_W] = {`LRM_LANE_W{en[k]}};
    end
  endfunction

  // 8-bit lanes placed into the 9-bit lane slots
  function [`LRM_DATA_W-1:0] lrm_spread8;
    input [`LRM_DATA_W-1:0] d;
    integer k;
    begin
      lrm_spread8 = `LRM_RST_DATA;
      for (k = 0; k < `LRM_LANES; k = k + 1)
        lrm_spread8[k*`LRM_LANE_W +: `LRM_BYTE_W] = d[k*`LRM_BYTE_W +: `LRM_BYTE_W];
    end
  endfunction

  // 9-bit lane slots packed back into 8-bit lanes
  function [`LRM_DATA_W-1:0] lrm_pack8;
    input [`LRM_DATA_W-1:0] d;
    integer k;
    begin
      lrm_pack8 = `LRM_RST_DATA;
      for (k = 0; k < `LRM_LANES; k = k + 1)
        lrm_pack8[k*`LRM_BYTE_W +: `LRM_BYTE_W] = d[k*`LRM_LANE_W +: `LRM_BYTE_W];
    end
  endfunction

  // Port data in lane layout, 8-bit variant spread out
  function [`LRM_DATA_W-1:0] lrm_lay;
    input [`LRM_DATA_W-1:0] d;
    input l8;
    begin
      lrm_lay = l8 ? lrm_spread8(d) : d;
    end
  endfunction

  // Array row holding a port word
  function [`LRM_ROW_AW-1:0] lrm_row;
    input [`LRM_ADDR_W-1:0] ad;
    input [1:0] w;
    begin
      case (w)
        `LRM_W18: lrm_row = ad[14:3];
        `LRM_W36: lrm_row = ad[13:2];
        `LRM_W72: lrm_row = ad[12:1];
        default: lrm_row = ad[11:0];
      endcase
    end
  endfunction

  // Bit offset of a port word inside its row
  function [7:0] lrm_sh;
    input [`LRM_ADDR_W-1:0] ad;
    input [1:0] w;
    begin
      case (w)
        `LRM_W18: lrm_sh = {4'h0, ad[2:0], 1'b0} * 8'h09;
        `LRM_W36: lrm_sh = {4'h0, ad[1:0], 2'b00} * 8'h09;
        `LRM_W72: lrm_sh = {4'h0, ad[0], 3'b000} * 8'h09;
        default: lrm_sh = `LRM_RST_SH;
      endcase
    end
  endfunction

  // Port word taken out of a row, unused lanes zero
  function [`LRM_DATA_W-1:0] lrm_ext;
    input [`LRM_ROW_W-1:0] row;
    input [7:0] sh;
    input [1:0] w;
    input l8;
    reg [`LRM_ROW_W-1:0] t;
    reg [`LRM_DATA_W-1:0] v;
    begin
      t = row >> sh;
      v = t[`LRM_DATA_W-1:0] & lrm_lanes(lrm_wmask(w));
      lrm_ext = l8 ? lrm_pack8(v) : v;
    end
  endfunction

  wire is144 = (cfg_width == `LRM_W144);
  wire bad144 = is144 & ~cfg_simple;
  wire wide = cfg_simple & is144;

  reg a_ien, a_iclr, a_oen, a_oclr;
  reg b_ien, b_iclr, b_oen, b_oclr;
  reg b_den, b_dclr;

  // Enable and clear routing per clocking mode
  always @*
  begin
    a_ien = a_in_clken;
    a_iclr = a_in_clr;
    b_ien = b_in_clken;
    b_iclr = b_in_clr;
    a_oen = a_in_clken;
    a_oclr = a_in_clr;
    b_oen = b_in_clken;
    b_oclr = b_in_clr;
    case (cfg_clk_mode)
      `LRM_CK_INOUT:
      begin
        a_oen = a_out_clken;
        a_oclr = a_out_clr;
        b_oen = b_out_clken;
        b_oclr = b_out_clr;
      end
      `LRM_CK_RDWR:
      begin
        if (cfg_simple)
        begin
          a_oen = b_in_clken;
          a_oclr = b_in_clr;
        end
      end
      default:
      begin
        a_oen = a_in_clken;
        a_oclr = a_in_clr;
      end
    endcase
    // B data and mask belong to the write side in simple operation
    b_den = cfg_simple ? a_ien : b_ien;
    b_dclr = cfg_simple ? a_iclr : b_iclr;
  end

  reg a_vld_q, a_we_q;
  reg [`LRM_ADDR_W-1:0] a_addr_q;
  reg [`LRM_DATA_W-1:0] a_din_q;
  reg [`LRM_LANES-1:0] a_len_q;
  reg b_vld_q, b_we_q, b_rden_q;
  reg [`LRM_ADDR_W-1:0] b_addr_q;
  reg [`LRM_DATA_W-1:0] b_din_q;
  reg [`LRM_LANES-1:0] b_len_q;

  // Port A input registers on one enable and one clear
  always @(posedge core_clk)
  begin
    if (srst || a_iclr)
    begin
      a_vld_q <= 1'b0;
      a_we_q <= 1'b0;
      a_addr_q <= `LRM_RST_ADDR;
      a_din_q <= `LRM_RST_DATA;
      a_len_q <= `LRM_RST_LANE;
    end
    else
    begin
      a_vld_q <= a_ien;
      if (a_ien)
      begin
        a_we_q <= a_we;
        a_addr_q <= a_addr;
        a_din_q <= a_din;
        a_len_q <= a_lane_en;
      end
    end
  end

  // Port B strobe and address registers
  always @(posedge core_clk)
  begin
    if (srst || b_iclr)
    begin
      b_vld_q <= 1'b0;
      b_we_q <= 1'b0;
      b_addr_q <= `LRM_RST_ADDR;
    end
    else
    begin
      b_vld_q <= b_ien;
      if (b_ien)
      begin
        b_we_q <= b_we;
        b_addr_q <= b_addr;
      end
    end
  end

  // Port B data and mask registers, write side when simple
  always @(posedge core_clk)
  begin
    if (srst || b_dclr)
    begin
      b_din_q <= `LRM_RST_DATA;
      b_len_q <= `LRM_RST_LANE;
    end
    else if (b_den)
    begin
      b_din_q <= b_din;
      b_len_q <= b_lane_en;
    end
  end

  // Read strobe register, reset only
  always @(posedge core_clk)
  begin
    if (srst)
      b_rden_q <= 1'b0;
    else if (b_ien)
      b_rden_q <= b_rd_en;
  end

  reg m_a_wr, m_a_rd, m_b_wr, m_b_rd;
  reg [ROW_AW-1:0] m_a_addr, m_b_addr;
  reg [`LRM_ROW_W-1:0] m_a_wd, m_a_wm, m_b_wd, m_b_wm;
  reg [7:0] sh_a, sh_b;

  // Array port requests from the registered inputs
  always @*
  begin
    sh_a = lrm_sh(a_addr_q, cfg_width);
    sh_b = lrm_sh(b_addr_q, cfg_width);
    m_a_addr = lrm_row(a_addr_q, cfg_width);
    m_b_addr = lrm_row(b_addr_q, cfg_width);
    m_a_wd = {{`LRM_DATA_W{1'b0}}, lrm_lay(a_din_q, cfg_lane8)} << sh_a;
    m_a_wm = {{`LRM_DATA_W{1'b0}},
      lrm_lanes(a_len_q & lrm_wmask(cfg_width))} << sh_a;
    m_b_wd = {{`LRM_DATA_W{1'b0}}, lrm_lay(b_din_q, cfg_lane8)} << sh_b;
    m_b_wm = {{`LRM_DATA_W{1'b0}},
      lrm_lanes(b_len_q & lrm_wmask(cfg_width))} << sh_b;
    if (cfg_simple)
    begin
      // A writes, B reads
      m_a_wr = a_vld_q & a_we_q;
      m_a_rd = 1'b0;
      m_b_wr = 1'b0;
      m_b_rd = b_vld_q & b_rden_q;
      if (is144)
      begin
        m_a_wd = {lrm_lay(b_din_q, cfg_lane8), lrm_lay(a_din_q, cfg_lane8)};
        m_a_wm = {lrm_lanes(b_len_q), lrm_lanes(a_len_q)};
      end
    end
    else
    begin
      // The strobe alone picks write or read on each port
      m_a_wr = a_vld_q & a_we_q & ~bad144;
      m_a_rd = a_vld_q & ~a_we_q & ~bad144;
      m_b_wr = b_vld_q & b_we_q & ~bad144;
      m_b_rd = b_vld_q & ~b_we_q & ~bad144;
    end
  end

  wire [`LRM_ROW_W-1:0] ra, rb;

  lrm_mem #(
    .ROW_W(`LRM_ROW_W),
    .ROW_AW(ROW_AW)
  ) u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .a_wr(m_a_wr),
    .a_rd(m_a_rd),
    .a_addr(m_a_addr),
    .a_wdata(m_a_wd),
    .a_wmask(m_a_wm),
    .a_rdata_q(ra),
    .b_wr(m_b_wr),
    .b_rd(m_b_rd),
    .b_addr(m_b_addr),
    .b_wdata(m_b_wd),
    .b_wmask(m_b_wm),
    .b_rdata_q(rb)
  );

  reg [7:0] sh_a_q, sh_b_q;

  // Word offset follows each read into the array register
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      sh_a_q <= `LRM_RST_SH;
      sh_b_q <= `LRM_RST_SH;
    end
    else
    begin
      if (m_a_rd)
        sh_a_q <= sh_a;
      if (m_b_rd)
        sh_b_q <= sh_b;
    end
  end

  wire [`LRM_DATA_W-1:0] a_ext = wide ?
    lrm_ext(rb, `LRM_RST_SH, `LRM_W72, cfg_lane8) :
    lrm_ext(ra, sh_a_q, cfg_width, cfg_lane8);
  wire [`LRM_DATA_W-1:0] b_ext = wide ?
    lrm_ext({{`LRM_DATA_W{1'b0}}, rb[`LRM_ROW_W-1:`LRM_DATA_W]}, `LRM_RST_SH,
      `LRM_W72, cfg_lane8) :
    lrm_ext(rb, sh_b_q, cfg_width, cfg_lane8);

  reg [`LRM_DATA_W-1:0] a_hold_q, b_hold_q;

  // Optional output registers; enable and clear routed per clocking mode
  always @(posedge core_clk)
  begin
    if (srst || a_oclr)
      a_hold_q <= `LRM_RST_DATA;
    else if (a_oen)
      a_hold_q <= a_ext;
  end

  always @(posedge core_clk)
  begin
    if (srst || b_oclr)
      b_hold_q <= `LRM_RST_DATA;
    else if (b_oen)
      b_hold_q <= b_ext;
  end

  // Data outputs, bypass skips the output register stage
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      a_dout_q <= `LRM_RST_DATA;
      b_dout_q <= `LRM_RST_DATA;
      cfg_fault_q <= 1'b0;
    end
    else
    begin
      a_dout_q <= cfg_out_reg_a ? a_hold_q : a_ext;
      b_dout_q <= cfg_out_reg_b ? b_hold_q : b_ext;
      cfg_fault_q <= bad144;
    end
  end

endmodule

// ---- sim/lrm_ram_checker.sv ----
/* Port checker of lrm_ram.
   Assumes a bind onto lrm_ram, one clock, srst high. */
`timescale 1ns/10ps
module lrm_chk (
  input wire core_clk,
  input wire srst,
  input wire cfg_simple,
  input wire [1:0] cfg_width,
  input wire cfg_lane8,
  input wire [1:0] cfg_clk_mode,
  input wire cfg_out_reg_a,
  input wire a_in_clken,
  input wire a_in_clr,
  input wire a_out_clr,
  input wire a_we,
  input wire [71:0] a_dout_q,
  input wire b_in_clken,
  input wire b_in_clr,
  input wire b_out_clr,
  input wire b_rd_en,
  input wire [71:0] b_dout_q,
  input wire cfg_fault_q
);
  // Any clear that may zero an output
  wire any_clr = a_in_clr | b_in_clr | a_out_clr | b_out_clr;
  // Port A as a true port in independent mode
  wire a_plain = !cfg_simple && (cfg_clk_mode == 2'h0);
  // Settings bundle; outputs may move when any of it changes
  wire [6:0] cfg_all = {cfg_simple, cfg_width, cfg_lane8, cfg_clk_mode, cfg_out_reg_a};
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Outputs leave reset cleared
  property p_rst;
    $fell(srst) |-> (a_dout_q == 0) && (b_dout_q == 0) && !cfg_fault_q;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not clear after reset");
  // Wide word on true ports raises the fault
  property p_flt_on;
    (cfg_width == 2'h3) && !cfg_simple |=> cfg_fault_q;
  endproperty
  a_flt_on: assert property (p_flt_on)
    else $error("fault missing");
  // Legal settings keep the fault low
  property p_flt_off;
    (cfg_width != 2'h3) || cfg_simple |=> !cfg_fault_q;
  endproperty
  a_flt_off: assert property (p_flt_off)
    else $error("fault without cause");
  // A write cycle reads nothing, so the output holds
  property p_wr_hold;
    a_plain && !cfg_out_reg_a && a_in_clken && !a_in_clr && a_we
      |=> ##2 (any_clr || $stable(a_dout_q));
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write changed read data");
  // Enable low: nothing new reaches port A
  property p_a_idle;
    (a_plain && !a_in_clken && !any_clr && $stable(cfg_all)) [*3]
      |=> (any_clr || $stable(a_dout_q));
  endproperty
  a_a_idle: assert property (p_a_idle)
    else $error("output moved with enable low");
  // Output clear zeroes the output register
  property p_oclr;
    !cfg_simple && (cfg_clk_mode == 2'h1) && cfg_out_reg_a && a_out_clr
      |=> ##1 (a_dout_q == 0);
  endproperty
  a_oclr: assert property (p_oclr)
    else $error("output clear ignored");
  // No read strobe: read side output holds
  property p_no_rd;
    (cfg_simple && !(b_in_clken && b_rd_en) && !any_clr) [*3]
      |=> (any_clr || $stable(b_dout_q));
  endproperty
  a_no_rd: assert property (p_no_rd)
    else $error("read without strobe");
  // Fault blocks every access
  property p_flt_blk;
    (cfg_fault_q && !any_clr && $stable(cfg_all)) [*3]
      |=> any_clr || ($stable(a_dout_q) && $stable(b_dout_q));
  endproperty
  a_flt_blk: assert property (p_flt_blk)
    else $error("access during fault");
endmodule

// ---- sim/lrm_fab.sv ----
/* Fabric model: drives the request pins of both RAM ports.
   Assumes put is called at a falling edge of core_clk. */
`timescale 1ns/10ps
module lrm_fab (
  input wire core_clk,
  output reg a_in_clken,
  output reg a_we,
  output reg [15:0] a_addr,
  output reg [71:0] a_din,
  output reg [7:0] a_lane_en,
  output reg b_in_clken,
  output reg b_we,
  output reg b_rd_en,
  output reg [15:0] b_addr,
  output reg [71:0] b_din,
  output reg [7:0] b_lane_en
);
  // Idle at start, lane masks at their default
  initial
  begin
    {a_in_clken, a_we, b_in_clken, b_we, b_rd_en} = 5'h00;
    {a_addr, b_addr, a_din, b_din} = 176'h0;
    {a_lane_en, b_lane_en} = 16'hffff;
  end

  // One request per port, held for n cycles
  task put(input ea, input wa, input [15:0] aa, input [71:0] da, input [7:0] la,
    input eb, input wb, input rb, input [15:0] ab, input [71:0] db, input [7:0] lb,
    input integer n);
  begin
    a_in_clken = ea;
    a_we = wa;
    b_in_clken = eb;
    b_we = wb;
    b_rd_en = rb;
    // Unused address and data lines toggle, no stale value
    a_addr = ea ? aa : ~a_addr;
    b_addr = eb ? ab : ~b_addr;
    a_din = wa ? da : ~a_din;
    b_din = (wa | wb) ? db : ~b_din;
    a_lane_en = la;
    b_lane_en = lb;
    repeat (n) @(negedge core_clk);
  end
  endtask
endmodule

// ---- sim/lrm_ram_tb.sv ----
/* Bench of lrm_ram: masked writes in all widths but 128, enable and clear,
   output register, wide simple mode and its fault.
   Assumes lrm_fab drives requests at falling edges. */
`timescale 1ns/10ps
`include "lrm_regs.vh"
`define CHK(g, e) chk((g), (e))
module lrm_ram_tb;
  reg core_clk = 1'h0;
  reg srst = 1'h1;
  reg cfg_simple = 1'h0;
  reg [1:0] cfg_width = `LRM_W72;
  reg cfg_lane8 = 1'h0;
  reg [1:0] cfg_clk_mode = `LRM_CK_INDEP;
  reg cfg_out_reg_a = 1'h0;
  reg cfg_out_reg_b = 1'h0;
  reg a_out_clken = 1'h1;
  reg b_out_clken = 1'h1;
  reg a_in_clr = 1'h0;
  reg a_out_clr = 1'h0;
  reg b_in_clr = 1'h0;
  reg b_out_clr = 1'h0;
  wire a_in_clken, a_we, b_in_clken, b_we, b_rd_en, cfg_fault_q;
  wire [15:0] a_addr, b_addr;
  wire [71:0] a_din, b_din, a_dout_q, b_dout_q;
  wire [7:0] a_lane_en, b_lane_en;
  integer err_total = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer w;
  reg [143:0] old_v = {2{72'h0f1e2d3c4b5a697887}};
  reg [143:0] new_v = {2{72'hf0e1d2c3b4a5968778}};
  reg [143:0] exp_v, wm;
  reg [15:0] m;

  // Clock, 50 ns period
  always #25 core_clk = ~core_clk;

  lrm_fab u_fab (.core_clk(core_clk), .a_in_clken(a_in_clken), .a_we(a_we), .a_addr(a_addr),
    .a_din(a_din), .a_lane_en(a_lane_en), .b_in_clken(b_in_clken), .b_we(b_we),
    .b_rd_en(b_rd_en), .b_addr(b_addr), .b_din(b_din), .b_lane_en(b_lane_en));

  lrm_ram u_dut (.core_clk(core_clk), .srst(srst), .cfg_simple(cfg_simple),
    .cfg_width(cfg_width), .cfg_lane8(cfg_lane8), .cfg_clk_mode(cfg_clk_mode),
    .cfg_out_reg_a(cfg_out_reg_a), .cfg_out_reg_b(cfg_out_reg_b), .a_in_clken(a_in_clken),
    .a_out_clken(a_out_clken), .a_in_clr(a_in_clr), .a_out_clr(a_out_clr), .a_we(a_we),
    .a_addr(a_addr), .a_din(a_din), .a_lane_en(a_lane_en), .a_dout_q(a_dout_q),
    .b_in_clken(b_in_clken), .b_out_clken(b_out_clken), .b_in_clr(b_in_clr),
    .b_out_clr(b_out_clr), .b_we(b_we), .b_rd_en(b_rd_en), .b_addr(b_addr), .b_din(b_din),
    .b_lane_en(b_lane_en), .b_dout_q(b_dout_q), .cfg_fault_q(cfg_fault_q));

  // Compare and count
  task chk(input [143:0] got, input [143:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // Expected word: new lanes over old ones under a mask
  function [143:0] merge(input [143:0] o, input [143:0] n, input [15:0] mk, input l8);
    integer i;
  begin
    for (i = 0; i < 144; i = i + 1)
      merge[i] = mk[l8 ? i / 8 : i / 9] ? n[i] : o[i];
  end
  endfunction

  // Access helpers for true ports, wide words and idle
  task wr(input p, input [15:0] ad, input [71:0] d, input [7:0] mk);
    u_fab.put(!p, 1'h1, ad, d, mk, p, 1'h1, 1'h0, ad, d, mk, 1);
  endtask
  task rd(input p, input [15:0] ad, input integer n);
    u_fab.put(!p, 1'h0, ad, 72'h0, 8'hff, p, 1'h0, 1'h0, ad, 72'h0, 8'hff, n);
  endtask
  task w144(input [143:0] d, input [15:0] mk);
    u_fab.put(1'h1, 1'h1, 16'h0003, d[71:0], mk[7:0], 1'h0, 1'h0, 1'h0, 16'h0003,
      d[143:72], mk[15:8], 1);
  endtask
  task r144(input rb);
    u_fab.put(1'h0, 1'h0, 16'h0003, 72'h0, 8'hff, 1'h1, 1'h0, rb, 16'h0003, 72'h0, 8'hff, 3);
  endtask
  task idle;
    u_fab.put(1'h0, 1'h0, 16'h0, 72'h0, 8'hff, 1'h0, 1'h0, 1'h0, 16'h0, 72'h0, 8'hff, 1);
  endtask

  // Verdict and end of run
  task summarize;
  begin
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // Hang guard, far above the run length
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      err_total = err_total + 1;
      summarize;
    end
  end

  // Test sequence
  initial
  begin
    repeat (4) @(negedge core_clk);
    srst = 1'h0;
    @(negedge core_clk);
    `CHK({cfg_fault_q, a_dout_q}, 73'h0);
    `CHK(b_dout_q, 72'h0);
    // Widths 18, 36 and 72 with 9 and 8 bit lanes, written on one port, read on the other
    m = 16'h00a5;
    for (w = 0; w < 6; w = w + 1)
    begin
      cfg_width = 2'(w % 3);
      cfg_lane8 = (w > 2);
      wm = {144{1'h1}} >> (144 - (2 << (w % 3)) * (9 - w / 3));
      wr(w[0], 16'h0011 + w[15:0], old_v[71:0], 8'hff);
      wr(w[0], 16'h0011 + w[15:0], new_v[71:0], m[7:0]);
      rd(!w[0], 16'h0011 + w[15:0], 3);
      exp_v = merge(old_v, new_v, m, w > 2);
      `CHK({72'h0, w[0] ? a_dout_q : b_dout_q} & wm, exp_v & wm);
    end
    // Writes with enable low and with clear high are refused
    cfg_width = `LRM_W72;
    cfg_lane8 = 1'h0;
    wr(1'h0, 16'h0020, old_v[71:0], 8'hff);
    u_fab.put(1'h0, 1'h1, 16'h0020, new_v[71:0], 8'hff, 1'h0, 1'h0, 1'h0, 16'h0,
      72'h0, 8'hff, 3);
    a_in_clr = 1'h1;
    wr(1'h0, 16'h0020, new_v[71:0], 8'hff);
    a_in_clr = 1'h0;
    rd(1'h0, 16'h0020, 3);
    `CHK(a_dout_q, old_v[71:0]);
    // Output register: one more cycle, frozen by its enable, zeroed by its clear
    cfg_clk_mode = `LRM_CK_INOUT;
    cfg_out_reg_a = 1'h1;
    wr(1'h0, 16'h0021, new_v[71:0], 8'hff);
    rd(1'h0, 16'h0021, 3);
    `CHK(a_dout_q, old_v[71:0]);
    rd(1'h0, 16'h0021, 1);
    `CHK(a_dout_q, new_v[71:0]);
    a_out_clken = 1'h0;
    rd(1'h0, 16'h0020, 4);
    `CHK(a_dout_q, new_v[71:0]);
    a_out_clken = 1'h1;
    a_out_clr = 1'h1;
    rd(1'h0, 16'h0020, 1);
    a_out_clr = 1'h0;
    idle;
    `CHK(a_dout_q, 72'h0);
    cfg_out_reg_a = 1'h0;
    // Port B output register: cleared, then loaded one stage after the read
    cfg_out_reg_b = 1'h1;
    b_out_clr = 1'h1;
    rd(1'h1, 16'h0021, 1);
    b_out_clr = 1'h0;
    idle;
    `CHK(b_dout_q, 72'h0);
    rd(1'h1, 16'h0021, 4);
    `CHK(b_dout_q, new_v[71:0]);
    cfg_out_reg_b = 1'h0;
    // Wide simple mode: sixteen lanes over both ports, read strobe on the read side
    cfg_simple = 1'h1;
    cfg_width = `LRM_W144;
    cfg_clk_mode = `LRM_CK_RDWR;
    m = 16'h8137;
    w144(old_v, 16'hffff);
    w144(new_v, m);
    r144(1'h1);
    exp_v = merge(old_v, new_v, m, 1'h0);
    `CHK({b_dout_q, a_dout_q}, exp_v);
    w144(old_v, 16'hffff);
    r144(1'h0);
    `CHK({b_dout_q, a_dout_q}, exp_v);
    // Wide word on true ports: fault raised, access blocked
    cfg_simple = 1'h0;
    cfg_clk_mode = `LRM_CK_INDEP;
    idle;
    `CHK(cfg_fault_q, 1'h1);
    w144(new_v, 16'hffff);
    rd(1'h1, 16'h0003, 3);
    // Faulted wide width shows the low half of the last row read
    `CHK(b_dout_q, exp_v[71:0]);
    cfg_simple = 1'h1;
    idle;
    r144(1'h1);
    `CHK({b_dout_q, a_dout_q}, old_v);
    summarize;
  end
endmodule

bind lrm_ram lrm_chk u_chk (.core_clk(core_clk), .srst(srst), .cfg_simple(cfg_simple),
  .cfg_width(cfg_width), .cfg_lane8(cfg_lane8), .cfg_clk_mode(cfg_clk_mode),
  .cfg_out_reg_a(cfg_out_reg_a),
  .a_in_clken(a_in_clken), .a_in_clr(a_in_clr), .a_out_clr(a_out_clr), .a_we(a_we),
  .a_dout_q(a_dout_q), .b_in_clken(b_in_clken), .b_in_clr(b_in_clr), .b_out_clr(b_out_clr),
  .b_rd_en(b_rd_en), .b_dout_q(b_dout_q), .cfg_fault_q(cfg_fault_q));
